//--- verilog/ddc_pkg.sv
// Shared constants and types of the DDR3 command decoder.
package ddc_pkg;
    // ------------------------------------------------------------------
    // Command encodings as {RAS#, CAS#, WE#} with CS# low
    // ------------------------------------------------------------------
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_ZQ  = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // ------------------------------------------------------------------
    // Address bit positions and mode register fields
    // ------------------------------------------------------------------
    localparam int         AP_BIT     = 10;
    localparam int         BC_BIT     = 12;
    localparam int         MR_BL_LSB  = 0;
    localparam int         MR_BT_BIT  = 3;
    localparam logic [1:0] BL_FIXED8  = 2'h0;
    localparam logic [1:0] BL_OTF     = 2'h1;
    localparam logic [1:0] BL_FIXED4  = 2'h2;
    localparam logic [15:0] MR_RESET  = 16'h0000;
    localparam int         NUM_MR     = 4;
    localparam int         NUM_BANKS  = 8;
    localparam int         BANK_BITS  = 3;
    localparam int         ADDR_BITS  = 16;
    localparam int         DQ_BITS    = 8;
    localparam int         BURST_BITS = 3;

    // ------------------------------------------------------------------
    // Burst lengths in clocks, two words per clock
    // ------------------------------------------------------------------
    localparam logic [2:0] CLKS_BL8 = 3'h4;
    localparam logic [2:0] CLKS_BC4 = 3'h2;
    localparam int         RD_FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        PWR_NORMAL   = 2'b00,
        PWR_DOWN     = 2'b01,
        PWR_SELF_REF = 2'b10
    } ddc_pwr_t;
endpackage

//--- verilog/ddc_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module ddc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != FULL);
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];

    always_comb begin
        push        = in_valid & in_ready;
        pop         = out_valid & out_ready;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + AW'(1);
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            next_count = count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_count = count - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end
endmodule
`default_nettype wire

//--- verilog/ddc_command_decode.sv
// DDR3 command decoder with bank control, burst engine and read buffer.
//
// Overview of operation
// R1: Activate with CKE high opens addressed row in the bank on BA.
// R2: Controller activates only idle banks, reads and writes only active ones.
// R3: Write command decoded, burst length from mode register unless on-the-fly.
// R4: Read command decoded, burst length handled as for writes.
// R5: On-the-fly mode: A12 low gives four beats, A12 high eight beats.
// R6: A10 gives auto-precharge on bursts; on precharge, A10 selects all banks.
// R7: Column bits sampled with read or write give the burst start column.
// R8: Mode register set loads register chosen by BA; controller issues it idle.
// R9: Previous and current CKE compared; refresh with falling CKE enters self refresh.
// R10: Falling CKE with NOP or deselect enters power-down.
// R11: Rising CKE leaves power-down or self refresh from any state.
// R12: Write beats whose mask is high are discarded, others stored.
// R13: Storage is eight banks; one core access serves an eight-word burst.
// R14: Data moves two words per clock, one per half clock.
// R15: Bursts last eight or four beats in the programmed burst order.
// R16: Controller completes initialisation before normal traffic.
// R17: Controller sends only NOP or deselect between last mode set and long calibration.
// R18: CS# high ignores inputs; NOP encoding takes no action.
// R19: Calibration command when idle: A10 high long, A10 low short.
// R20: Mode register burst length field selects fixed eight, fixed four or on-the-fly.
`timescale 1ns/1ps
`default_nettype none
module ddc_command_decode #(
    parameter int ROW_STORE_BITS = 1,
    parameter int COL_HI_BITS    = 1
) (
    input  wire logic                          CLK,
    input  wire logic                          SYS_RST,
    input  wire logic                          CKE,
    input  wire logic                          CS_N,
    input  wire logic                          RAS_N,
    input  wire logic                          CAS_N,
    input  wire logic                          WE_N,
    input  wire logic [ddc_pkg::BANK_BITS-1:0] BA,
    input  wire logic [ddc_pkg::ADDR_BITS-1:0] ADDR,
    input  wire logic [ddc_pkg::DQ_BITS-1:0]   WR_RISE,
    input  wire logic [ddc_pkg::DQ_BITS-1:0]   WR_FALL,
    input  wire logic                          DM_RISE,
    input  wire logic                          DM_FALL,
    input  wire logic                          RD_READY,
    output logic [ddc_pkg::DQ_BITS-1:0]        RD_RISE,
    output logic [ddc_pkg::DQ_BITS-1:0]        RD_FALL,
    output logic                               RD_VALID,
    output logic [ddc_pkg::NUM_BANKS-1:0]      BANK_OPEN,
    output logic                               BURST_BUSY,
    output logic                               POWER_DOWN,
    output logic                               SELF_REFRESH,
    output logic                               REFRESH,
    output logic                               ZQ_LONG,
    output logic                               ZQ_SHORT
);
    localparam int RB = ROW_STORE_BITS;
    localparam int CH = COL_HI_BITS;
    localparam int BB = ddc_pkg::BURST_BITS;
    localparam int IW = ddc_pkg::BANK_BITS + RB + CH + BB;
    localparam int DW = ddc_pkg::DQ_BITS;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    ddc_pkg::ddc_pwr_t pwr;
    ddc_pkg::ddc_pwr_t next_pwr;
    logic       cke_prev;
    logic [2:0] cmd;
    logic       cmd_ok;
    logic       is_act;
    logic       is_rd;
    logic       is_wr;
    logic       is_pre;
    logic       is_mrs;
    logic       is_zq;
    logic       chop_req;
    logic [1:0] bl_mode;
    logic [ddc_pkg::NUM_BANKS-1:0] bank_open;
    logic [15:0]                   mr [ddc_pkg::NUM_MR];
    logic                          bst_active;
    logic                          bst_ap;
    logic [2:0]                    bst_bank;

    assign cmd     = {RAS_N, CAS_N, WE_N};
    assign bl_mode = mr[0][ddc_pkg::MR_BL_LSB +: 2];
    // R9 both CKE samples
    // R18 deselect and NOP ignored
    assign cmd_ok  = cke_prev & CKE & !CS_N & (pwr == ddc_pkg::PWR_NORMAL);
    // R1 activate decode
    assign is_act  = cmd_ok & (cmd == ddc_pkg::CMD_ACT) & !bank_open[BA];
    // R4 read decode
    assign is_rd   = cmd_ok & (cmd == ddc_pkg::CMD_RD) & bank_open[BA] & !bst_active;
    // R3 write decode
    assign is_wr   = cmd_ok & (cmd == ddc_pkg::CMD_WR) & bank_open[BA] & !bst_active;
    assign is_pre  = cmd_ok & (cmd == ddc_pkg::CMD_PRE);
    // R8 load when idle
    assign is_mrs  = cmd_ok & (cmd == ddc_pkg::CMD_MRS) & (bank_open == '0) & !bst_active;
    assign is_zq   = cmd_ok & (cmd == ddc_pkg::CMD_ZQ) & (bank_open == '0);
    // R20 burst length field
    // R5 chop on A12
    assign chop_req = (bl_mode == ddc_pkg::BL_FIXED4) |
                      ((bl_mode == ddc_pkg::BL_OTF) & !ADDR[ddc_pkg::BC_BIT]);

    // ------------------------------------------------------------------
    // Bank, mode and power state
    // ------------------------------------------------------------------
    logic [ddc_pkg::NUM_BANKS-1:0] next_bank_open;
    logic [RB-1:0]                 open_row [ddc_pkg::NUM_BANKS];
    logic [RB-1:0]                 next_open_row [ddc_pkg::NUM_BANKS];
    logic [15:0]                   next_mr [ddc_pkg::NUM_MR];
    logic                          next_refresh;
    logic                          next_zq_long;
    logic                          next_zq_short;
    logic                          bst_done;

    always_comb begin
        next_bank_open = bank_open;
        next_open_row  = open_row;
        next_mr        = mr;
        next_pwr       = pwr;
        next_refresh   = cmd_ok & (cmd == ddc_pkg::CMD_REF);
        // R19 long or short calibration
        next_zq_long   = is_zq & ADDR[ddc_pkg::AP_BIT];
        next_zq_short  = is_zq & !ADDR[ddc_pkg::AP_BIT];
        // R6 auto-precharge after burst
        if (bst_done && bst_ap) begin
            next_bank_open[bst_bank] = 1'b0;
        end
        if (is_act) begin
            next_bank_open[BA] = 1'b1;
            next_open_row[BA]  = ADDR[RB-1:0];
        end
        // R6 single or all banks
        if (is_pre) begin
            if (ADDR[ddc_pkg::AP_BIT]) begin
                next_bank_open = '0;
            end else begin
                next_bank_open[BA] = 1'b0;
            end
        end
        if (is_mrs) begin
            next_mr[BA[1:0]] = ADDR;
        end
        unique case (pwr)
            ddc_pkg::PWR_NORMAL: begin
                if (cke_prev && !CKE) begin
                    // R9 self refresh entry
                    if (!CS_N && cmd == ddc_pkg::CMD_REF) begin
                        next_pwr = ddc_pkg::PWR_SELF_REF;
                    // R10 power-down entry
                    end else if (CS_N || cmd == ddc_pkg::CMD_NOP) begin
                        next_pwr = ddc_pkg::PWR_DOWN;
                    end
                end
            end
            ddc_pkg::PWR_DOWN, ddc_pkg::PWR_SELF_REF: begin
                // R11 exit on rising CKE
                if (!cke_prev && CKE) begin
                    next_pwr = ddc_pkg::PWR_NORMAL;
                end
            end
            default: next_pwr = ddc_pkg::PWR_NORMAL;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cke_prev  <= 1'b0;
            bank_open <= '0;
            open_row  <= '{default: '0};
            mr        <= '{default: ddc_pkg::MR_RESET};
            pwr       <= ddc_pkg::PWR_NORMAL;
            REFRESH   <= 1'b0;
            ZQ_LONG   <= 1'b0;
            ZQ_SHORT  <= 1'b0;
            POWER_DOWN   <= 1'b0;
            SELF_REFRESH <= 1'b0;
        end else begin
            cke_prev  <= CKE;
            bank_open <= next_bank_open;
            open_row  <= next_open_row;
            mr        <= next_mr;
            pwr       <= next_pwr;
            REFRESH   <= next_refresh;
            ZQ_LONG   <= next_zq_long;
            ZQ_SHORT  <= next_zq_short;
            POWER_DOWN   <= (next_pwr == ddc_pkg::PWR_DOWN);
            SELF_REFRESH <= (next_pwr == ddc_pkg::PWR_SELF_REF);
        end
    end

    assign BANK_OPEN    = bank_open;

    // ------------------------------------------------------------------
    // Burst engine and bank storage
    // ------------------------------------------------------------------
    logic          bst_write;
    logic          bst_ilv;
    logic          bst_chop;
    logic [2:0]    bst_len;
    logic [2:0]    bst_cnt;
    logic [RB-1:0] bst_row;
    logic [CH-1:0] bst_colhi;
    logic [BB-1:0] bst_col;
    logic          next_bst_active;
    logic          next_bst_write;
    logic          next_bst_ap;
    logic          next_bst_ilv;
    logic          next_bst_chop;
    logic [2:0]    next_bst_len;
    logic [2:0]    next_bst_cnt;
    logic [2:0]    next_bst_bank;
    logic [RB-1:0] next_bst_row;
    logic [CH-1:0] next_bst_colhi;
    logic [BB-1:0] next_bst_col;
    logic          bst_step;
    logic [IW-1:0] idx0;
    logic [IW-1:0] idx1;
    logic          fifo_in_ready;
    logic [DW-1:0] mem [ddc_pkg::NUM_BANKS << (RB + CH + BB)];

    // R15 burst order by type
    function automatic logic [BB-1:0] beat_col(input logic [BB-1:0] start,
                                               input logic [BB-1:0] k,
                                               input logic          chop,
                                               input logic          ilv);
        logic [BB-1:0] col;
        col = start + k;
        if (ilv) begin
            col = start ^ k;
        end else if (chop) begin
            col = {start[2], 2'(start[1:0] + k[1:0])};
        end
        return col;
    endfunction

    // R13 eight banks in one array
    // R14 two words per clock
    assign idx0 = {bst_bank, bst_row, bst_colhi,
                   beat_col(bst_col, {bst_cnt[1:0], 1'b0}, bst_chop, bst_ilv)};
    assign idx1 = {bst_bank, bst_row, bst_colhi,
                   beat_col(bst_col, {bst_cnt[1:0], 1'b1}, bst_chop, bst_ilv)};
    // A read beat waits while the read buffer is full.
    assign bst_step = bst_active & (bst_write | fifo_in_ready);
    assign bst_done = bst_step & (bst_cnt == bst_len - 3'(1));

    always_comb begin
        next_bst_active = bst_active;
        next_bst_write  = bst_write;
        next_bst_ap     = bst_ap;
        next_bst_ilv    = bst_ilv;
        next_bst_chop   = bst_chop;
        next_bst_len    = bst_len;
        next_bst_cnt    = bst_cnt;
        next_bst_bank   = bst_bank;
        next_bst_row    = bst_row;
        next_bst_colhi  = bst_colhi;
        next_bst_col    = bst_col;
        if (bst_done) begin
            next_bst_active = 1'b0;
        end else if (bst_step) begin
            next_bst_cnt = bst_cnt + 3'(1);
        end
        if (is_rd || is_wr) begin
            next_bst_active = 1'b1;
            next_bst_write  = is_wr;
            next_bst_ap     = ADDR[ddc_pkg::AP_BIT];
            next_bst_ilv    = mr[0][ddc_pkg::MR_BT_BIT];
            next_bst_chop   = chop_req;
            next_bst_len    = chop_req ? ddc_pkg::CLKS_BC4 : ddc_pkg::CLKS_BL8;
            next_bst_cnt    = '0;
            next_bst_bank   = BA;
            next_bst_row    = open_row[BA];
            // R7 start column
            next_bst_colhi  = ADDR[BB +: CH];
            next_bst_col    = ADDR[BB-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            bst_active <= 1'b0;
            bst_write  <= 1'b0;
            bst_ap     <= 1'b0;
            bst_ilv    <= 1'b0;
            bst_chop   <= 1'b0;
            bst_len    <= ddc_pkg::CLKS_BL8;
            bst_cnt    <= '0;
            bst_bank   <= '0;
            bst_row    <= '0;
            bst_colhi  <= '0;
            bst_col    <= '0;
        end else begin
            bst_active <= next_bst_active;
            bst_write  <= next_bst_write;
            bst_ap     <= next_bst_ap;
            bst_ilv    <= next_bst_ilv;
            bst_chop   <= next_bst_chop;
            bst_len    <= next_bst_len;
            bst_cnt    <= next_bst_cnt;
            bst_bank   <= next_bst_bank;
            bst_row    <= next_bst_row;
            bst_colhi  <= next_bst_colhi;
            bst_col    <= next_bst_col;
        end
    end

    assign BURST_BUSY = bst_active;

    // R12 masked beats discarded
    always_ff @(posedge CLK) begin
        if (bst_step && bst_write && !DM_RISE) begin
            mem[idx0] <= WR_RISE;
        end
        if (bst_step && bst_write && !DM_FALL) begin
            mem[idx1] <= WR_FALL;
        end
    end

    // ------------------------------------------------------------------
    // Read buffer and output register
    // ------------------------------------------------------------------
    logic            fifo_out_valid;
    logic            fifo_out_ready;
    logic [2*DW-1:0] fifo_out_data;
    logic            next_rd_valid;
    logic [DW-1:0]   next_rd_rise;
    logic [DW-1:0]   next_rd_fall;

    ddc_fifo #(
        .WIDTH (2 * DW),
        .DEPTH (ddc_pkg::RD_FIFO_DEPTH)
    ) u_rd_fifo (
        .clk       (CLK),
        .rst       (SYS_RST),
        .in_valid  (bst_active & !bst_write),
        .in_ready  (fifo_in_ready),
        .in_data   ({mem[idx0], mem[idx1]}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign fifo_out_ready = !RD_VALID | RD_READY;

    always_comb begin
        next_rd_valid = RD_VALID & !RD_READY;
        next_rd_rise  = RD_RISE;
        next_rd_fall  = RD_FALL;
        if (fifo_out_valid && fifo_out_ready) begin
            next_rd_valid = 1'b1;
            next_rd_rise  = fifo_out_data[2*DW-1:DW];
            next_rd_fall  = fifo_out_data[DW-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RD_VALID <= 1'b0;
            RD_RISE  <= '0;
            RD_FALL  <= '0;
        end else begin
            RD_VALID <= next_rd_valid;
            RD_RISE  <= next_rd_rise;
            RD_FALL  <= next_rd_fall;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    AST_ACT_OPENS: assert property (is_act |=> BANK_OPEN[$past(BA)]) // R1
        else $error("Activate did not open the bank.");
    AST_PRE_ALL: assert property (is_pre && ADDR[ddc_pkg::AP_BIT] |=> BANK_OPEN == '0) // R6
        else $error("Precharge all left a bank open.");
    AST_MRS_LOAD: assert property (is_mrs |=> mr[$past(BA[1:0])] == $past(ADDR)) // R8
        else $error("Mode register not loaded.");
    AST_SR_ENTRY: assert property (pwr == ddc_pkg::PWR_NORMAL && cke_prev && !CKE
        && !CS_N && cmd == ddc_pkg::CMD_REF |=> SELF_REFRESH && !POWER_DOWN) // R9
        else $error("Self refresh not entered.");
    AST_PD_ENTRY: assert property (pwr == ddc_pkg::PWR_NORMAL && cke_prev && !CKE
        && (CS_N || cmd == ddc_pkg::CMD_NOP) |=> POWER_DOWN) // R10
        else $error("Power-down not entered.");
    AST_PD_EXIT: assert property (POWER_DOWN && !cke_prev && CKE |=> !POWER_DOWN) // R11
        else $error("Power-down not left.");
    AST_BC4_LEN: assert property (is_wr && chop_req |=> bst_active [*2] ##1 !bst_active) // R5
        else $error("Chopped write burst length wrong.");
    AST_BL8_LEN: assert property (is_wr && !chop_req |=> bst_active [*4] ##1 !bst_active) // R15
        else $error("Full write burst length wrong.");
    AST_DM_MASK: assert property (bst_step && bst_write && DM_RISE
        |=> mem[$past(idx0)] == $past(mem[idx0])) // R12
        else $error("Masked write beat was stored.");
    AST_DESEL: assert property (CS_N && !bst_active && pwr == ddc_pkg::PWR_NORMAL
        |=> $stable(BANK_OPEN)) // R18
        else $error("Deselect changed bank state.");
    AST_ZQ: assert property (is_zq |=> ZQ_LONG == $past(ADDR[ddc_pkg::AP_BIT])
        && ZQ_SHORT != ZQ_LONG) // R19
        else $error("Calibration kind wrong.");
    AST_RD_DATA: assert property (is_rd |-> ##[1:40] RD_VALID) // R4
        else $error("Read produced no data.");

    COV_READ_AP: cover property (is_rd && ADDR[ddc_pkg::AP_BIT] ##[1:20] !bst_active);
    COV_FIFO_FULL: cover property (bst_active && !bst_write && !fifo_in_ready);
    COV_SELF_REF: cover property (SELF_REFRESH ##[1:50] !SELF_REFRESH);
endmodule
`default_nettype wire

//--- sim/ddc_ctrl_model.sv
// Controller-side model that drives command, address and write beats.
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl_model (
    input  wire logic        clk,
    output var  logic        cke,
    output var  logic        cs_n,
    output var  logic        ras_n,
    output var  logic        cas_n,
    output var  logic        we_n,
    output var  logic [2:0]  ba,
    output var  logic [15:0] addr,
    output var  logic [7:0]  wr_rise,
    output var  logic [7:0]  wr_fall,
    output var  logic        dm_rise,
    output var  logic        dm_fall
);
    // CKE starts low and the device deselected, as after reset.
    initial {cke, cs_n, ras_n, cas_n, we_n, ba, addr} = {5'h0F, 3'h0, 16'h0000};
    initial {wr_rise, wr_fall, dm_rise, dm_fall} = 18'h00000;
    task automatic issue(input logic ck, input logic cs, input logic [2:0] op,
                         input logic [2:0] b, input logic [15:0] a);
        @(posedge clk);
        {cke, cs_n, ras_n, cas_n, we_n, ba} <= {ck, cs, op, b};
        // A deselected bus must not look like a held address.
        addr <= cs ? ~addr : a;
        wr_rise <= ~wr_rise;
        wr_fall <= ~wr_fall;
        {dm_rise, dm_fall} <= 2'h0;
    endtask
    task automatic beat(input logic [15:0] d, input logic [1:0] m);
        @(posedge clk);
        cs_n <= 1'b1;
        {wr_rise, wr_fall, dm_rise, dm_fall} <= {d, m};
    endtask
endmodule
`default_nettype wire

//--- sim/tb_ddr3_command_decode.sv
// Self-checking bench of the DDR3 command decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_ddr3_command_decode;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rd_ready = 1'b1;
    logic [31:0] seed = 32'h465BB4E4;
    logic [7:0]  mem [8];
    logic [15:0] exp_q [$];
    int          err_total = 0;
    int          n_compared = 0;
    wire logic        cke, cs_n, ras_n, cas_n, we_n, dm_r, dm_f, rd_v, busy, pd, sr, rf, zl, zs;
    wire logic [2:0]  ba;
    wire logic [15:0] addr;
    wire logic [7:0]  wr_r, wr_f, rd_r, rd_f, bank_open;
    wire logic [4:0]  st = {pd, sr, rf, zl, zs};
    ddc_ctrl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .wr_rise(wr_r), .wr_fall(wr_f), .dm_rise(dm_r),
        .dm_fall(dm_f));
    ddc_command_decode dut (.CLK(clk), .SYS_RST(rst), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
        .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr), .WR_RISE(wr_r), .WR_FALL(wr_f),
        .DM_RISE(dm_r), .DM_FALL(dm_f), .RD_READY(rd_ready), .RD_RISE(rd_r), .RD_FALL(rd_f),
        .RD_VALID(rd_v), .BANK_OPEN(bank_open), .BURST_BUSY(busy), .POWER_DOWN(pd),
        .SELF_REFRESH(sr), .REFRESH(rf), .ZQ_LONG(zl), .ZQ_SHORT(zs));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [2:0] pos(input logic [2:0] s, input int i, input logic ch);
        return ch ? {s[2], s[1:0] + 2'(i)} : s + 3'(i);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        n_compared++;
        if (got !== want) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Waits for the burst engine and the read queue to drain, within a bound.
    task automatic idle();
        int t;
        ctl.issue(1'b1, 1'b1, ddc_pkg::CMD_NOP, 3'h0, 16'h0000);
        for (t = 0; t < 200 && (busy !== 1'b0 || exp_q.size() != 0); t++) @(posedge clk);
        tick(1);
        if (t == 200) begin
            err_total++;
            $display("[FAIL] %0t burst never finished", $time);
            summarize();
        end
    endtask
    task automatic cmd(input logic [2:0] op, input logic [2:0] b, input logic [15:0] a);
        ctl.issue(1'b1, 1'b0, op, b, a);
        ctl.issue(1'b1, 1'b1, ddc_pkg::CMD_NOP, 3'h0, 16'h0000);
        // One-cycle pulses stand only until the next edge.
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic ch, input logic [1:0] m);
        logic [15:0] d;
        logic [1:0]  mk;
        ctl.issue(1'b1, 1'b0, ddc_pkg::CMD_WR, 3'h1, a);
        for (int k = 0; k < (ch ? 2 : 4); k++) begin
            d = 16'(rnd());
            mk = (k == 1) ? m : 2'h0;
            // masked words keep their old contents.
            if (!mk[1]) mem[pos(a[2:0], 2 * k, ch)] = d[15:8];
            if (!mk[0]) mem[pos(a[2:0], 2 * k + 1, ch)] = d[7:0];
            ctl.beat(d, mk);
        end
        #1 chk(16'(busy), 16'h0001);
        ctl.issue(1'b1, 1'b1, ddc_pkg::CMD_NOP, 3'h0, 16'h0000);
        #1 chk(16'(busy), 16'h0000);
        idle();
    endtask
    task automatic rd(input logic [15:0] a, input logic ch);
        ctl.issue(1'b1, 1'b0, ddc_pkg::CMD_RD, 3'h1, a);
        for (int k = 0; k < (ch ? 2 : 4); k++)
            exp_q.push_back({mem[pos(a[2:0], 2 * k, ch)], mem[pos(a[2:0], 2 * k + 1, ch)]});
        idle();
    endtask
    task automatic pwr(input logic [2:0] op, input logic [15:0] want);
        ctl.issue(1'b0, 1'b0, op, 3'h0, 16'h0000);
        ctl.issue(1'b0, 1'b1, ddc_pkg::CMD_NOP, 3'h0, 16'h0000);
        tick(1);
        chk(16'(st), want);
        ctl.issue(1'b1, 1'b0, ddc_pkg::CMD_ACT, 3'h1, 16'h0000);
        ctl.issue(1'b1, 1'b1, ddc_pkg::CMD_NOP, 3'h0, 16'h0000);
        tick(1);
        chk(16'({st, bank_open}), 16'h0000);
    endtask
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        rd_ready <= (rnd() > 32'h50000000);
        if (rd_v === 1'b1 && rd_ready === 1'b1)
            chk({rd_r, rd_f}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        idle();
        idle();
        cmd(ddc_pkg::CMD_MRS, 3'h0, 16'h0000);
        cmd(ddc_pkg::CMD_ACT, 3'h1, 16'h0000);
        chk(16'(bank_open), 16'h0002);
        ctl.issue(1'b1, 1'b1, ddc_pkg::CMD_ACT, 3'h2, 16'h0000);
        cmd(ddc_pkg::CMD_NOP, 3'h2, 16'h0000);
        chk(16'(bank_open), 16'h0002);
        wr(16'h0000, 1'b0, 2'h0);
        wr(16'h0003, 1'b0, 2'h2);
        wr(16'h0006, 1'b0, 2'h1);
        rd(16'h0402, 1'b0);
        chk(16'(bank_open), 16'h0000);
        cmd(ddc_pkg::CMD_MRS, 3'h0, 16'h0001);
        cmd(ddc_pkg::CMD_ACT, 3'h1, 16'h0000);
        wr(16'h0005, 1'b1, 2'h0);
        rd(16'h1000, 1'b0);
        cmd(ddc_pkg::CMD_PRE, 3'h1, 16'h0000);
        chk(16'(bank_open), 16'h0000);
        cmd(ddc_pkg::CMD_MRS, 3'h0, 16'h0002);
        cmd(ddc_pkg::CMD_ACT, 3'h1, 16'h0000);
        cmd(ddc_pkg::CMD_ACT, 3'h3, 16'h0000);
        chk(16'(bank_open), 16'h000A);
        rd(16'h1004, 1'b1);
        cmd(ddc_pkg::CMD_PRE, 3'h0, 16'h0400);
        chk(16'(bank_open), 16'h0000);
        cmd(ddc_pkg::CMD_REF, 3'h0, 16'h0000);
        chk(16'(st), 16'h0004);
        cmd(ddc_pkg::CMD_ZQ, 3'h0, 16'h0400);
        chk(16'(st), 16'h0002);
        cmd(ddc_pkg::CMD_ZQ, 3'h0, 16'h0000);
        chk(16'(st), 16'h0001);
        pwr(ddc_pkg::CMD_NOP, 16'h0010);
        pwr(ddc_pkg::CMD_REF, 16'h0008);
        summarize();
    end
endmodule
`default_nettype wire
